// *** core/laser_driver_status_config_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "laser_regs_cfg.svh"

module laser_driver_status_config_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register access port
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    // Same-clock sources
    input wire logic ram_init_done,
    input wire logic [7:0] temperature,
    input wire logic [9:0] conv1_result,
    input wire logic [9:0] conv2_result,
    // Asynchronous analog events and pins
    input wire laser_regs_pkg::event_t events,
    // Channel control
    output laser_regs_pkg::cfg1_t cfg1_q,
    output laser_regs_pkg::conv_route_t conv1_route_q,
    output logic overcurrent1_detect_en_q,
    output logic laser_off_q,
    output logic ch1_on_q,
    output logic ch2_on_q,
    output logic ch2_parallel_q
);

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic is_read(input logic en, input logic [7:0] a, input logic [7:0] t);
        is_read = en && (a == t);
    endfunction

    function automatic laser_regs_pkg::conv_route_t route_of(input logic [2:0] src,
                                                             input logic force_sel);
        case (src)
            3'h4: route_of = force_sel ? laser_regs_pkg::ROUTE_PHOTODIODE_FORCE
                                       : laser_regs_pkg::ROUTE_MON_SENSE;
            3'h5: route_of = laser_regs_pkg::ROUTE_MAIN_SUPPLY;
            3'h6: route_of = laser_regs_pkg::ROUTE_CH_SUPPLY;
            3'h7: route_of = laser_regs_pkg::ROUTE_DRIVER_OUT;
            default: route_of = laser_regs_pkg::ROUTE_OFF;
        endcase
    endfunction

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    laser_regs_pkg::event_t ev_s;

    pin_sync3 #(
        .WIDTH($bits(laser_regs_pkg::event_t))
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in(events),
        .sync_q(ev_s)
    );

    logic cfg_timeout_s;
    assign cfg_timeout_s = ev_s.cfg_mode && ev_s.cfg_timeout;

    // ----------------------------------------
    // Sticky status flags
    // ----------------------------------------
    logic rd_s0;
    logic rd_s1;
    logic [7:0] s0_set;
    logic [7:0] s1_set;
    logic [7:0] s0_flags;
    logic [7:0] s1_flags;

    assign rd_s0 = is_read(rd_en, addr, `ADDR_STATUS0);
    assign rd_s1 = is_read(rd_en, addr, `ADDR_STATUS1);

    always_comb begin
        s0_set = 8'h00;
        s0_set[`S0_RAM_INIT] = ram_init_done;
        s0_set[`S0_OVERTEMP] = ev_s.overtemp;
        s0_set[`S0_OVERCURRENT2] = ev_s.overcurrent2;
        s0_set[`S0_OVERCURRENT1] = ev_s.overcurrent1 && overcurrent1_detect_en_q;
        s0_set[`S0_OSC_WDOG] = ev_s.osc_fail;
    end

    always_comb begin
        s1_set = 8'h00;
        s1_set[`S1_CH1_SEEN] = ev_s.ch1_enable_pin;
        s1_set[`S1_CH2_SEEN] = ev_s.ch2_enable_pin;
        s1_set[`S1_CH1_SAT] = ev_s.ch1_sat;
        s1_set[`S1_CH2_SAT] = ev_s.ch2_sat;
        // Combined channels: a supply mismatch counts as a channel 1 fault
        s1_set[`S1_CH1_SUPPLY] = ev_s.ch1_supply_down
                               || (cfg1_q.merge && ev_s.supplies_differ);
        // Combined channels: either supply going down is reported here
        s1_set[`S1_CH2_SUPPLY] = ev_s.ch2_supply_down
                               || (cfg1_q.merge && ev_s.ch1_supply_down);
    end

    // Clears land on the same edge that captures the read data
    sticky_flag_bank #(
        .WIDTH(8)
    ) u_flags0 (
        .clock(clock),
        .reset(reset),
        .set_in(s0_set),
        .clear_in({8{rd_s0}}),
        .flags_q(s0_flags)
    );

    sticky_flag_bank #(
        .WIDTH(8)
    ) u_flags1 (
        .clock(clock),
        .reset(reset),
        .set_in(s1_set),
        .clear_in({8{rd_s1}}),
        .flags_q(s1_flags)
    );

    // ----------------------------------------
    // Converter low byte snapshots
    // ----------------------------------------
    logic [7:0] conv1_lo_q;
    logic [7:0] conv2_lo_q;

    // Without the snapshot a conversion finishing between the two byte reads
    // would give the host a torn result
    always_ff @(posedge clock) begin
        if (reset) begin
            conv1_lo_q <= 8'h00;
            conv2_lo_q <= 8'h00;
        end else begin
            if (is_read(rd_en, addr, `ADDR_CONV1_HI)) begin
                conv1_lo_q <= conv1_result[7:0];
            end
            if (is_read(rd_en, addr, `ADDR_CONV2_HI)) begin
                conv2_lo_q <= conv2_result[7:0];
            end
        end
    end

    // ----------------------------------------
    // Configuration writes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            {cfg1_q.conv_src, cfg1_q.offset_comp_en, cfg1_q.pin_enable_block,
             cfg1_q.monitor_resistor_off, cfg1_q.ext_cap_connect,
             cfg1_q.regulation_select} <= `RST_CH1_CTRL;
            cfg1_q.ovc_threshold <= `RST_OVC_THR;
            cfg1_q.monitor_resistor_code <= `RST_MON_RES;
            cfg1_q.compensation_current <= `RST_COMP;
            cfg1_q.saturation_threshold <= `RST_SAT_THR;
            cfg1_q.regulator_reference <= `RST_REF;
            cfg1_q.ext_transistor_enable <= 1'b0;
            cfg1_q.force_sense_select <= 1'b0;
            cfg1_q.current_range <= 1'b0;
            cfg1_q.merge <= 1'b0;
        end else if (wr_en) begin
            case (addr)
                `ADDR_CH1_CTRL: begin
                    {cfg1_q.conv_src, cfg1_q.offset_comp_en, cfg1_q.pin_enable_block,
                     cfg1_q.monitor_resistor_off, cfg1_q.ext_cap_connect,
                     cfg1_q.regulation_select} <= wdata;
                end
                `ADDR_CH1_OVC_THR: begin
                    cfg1_q.ovc_threshold <= wdata;
                end
                `ADDR_CH1_MON_RES: begin
                    cfg1_q.monitor_resistor_code <= wdata;
                end
                `ADDR_CH1_COMP_REF: begin
                    cfg1_q.compensation_current <= wdata[6:4];
                    cfg1_q.saturation_threshold <= wdata[3:2];
                    cfg1_q.regulator_reference[9:8] <= wdata[1:0];
                end
                `ADDR_CH1_REF_LO: begin
                    cfg1_q.regulator_reference[7:0] <= wdata;
                end
                `ADDR_RANGE_XT: begin
                    cfg1_q.current_range <= wdata[`RX_RANGE];
                    cfg1_q.force_sense_select <= wdata[`RX_FORCE];
                    cfg1_q.ext_transistor_enable <= wdata[`RX_EXT_TR];
                end
                `ADDR_GENERAL: begin
                    cfg1_q.merge <= wdata[`GEN_MERGE];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Channel control derived from configuration
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            conv1_route_q <= laser_regs_pkg::ROUTE_OFF;
        end else begin
            conv1_route_q <= route_of(cfg1_q.conv_src, cfg1_q.force_sense_select);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            overcurrent1_detect_en_q <= 1'b1;
        end else begin
            overcurrent1_detect_en_q <= !(cfg1_q.regulation_select
                                          && cfg1_q.ovc_threshold == `OVC_THR_OFF);
        end
    end

    // Outputs are dropped on a configuration timeout; overtemperature and
    // overcurrent shutdown live in the analog path, not here
    always_ff @(posedge clock) begin
        if (reset) begin
            laser_off_q <= 1'b1;
            ch1_on_q <= 1'b0;
            ch2_on_q <= 1'b0;
            ch2_parallel_q <= 1'b0;
        end else begin
            laser_off_q <= cfg_timeout_s;
            ch1_on_q <= ev_s.ch1_enable_pin && !cfg1_q.pin_enable_block
                        && !cfg_timeout_s;
            ch2_on_q <= ev_s.ch2_enable_pin && !cfg1_q.merge && !cfg_timeout_s;
            ch2_parallel_q <= cfg1_q.merge && ev_s.ch1_enable_pin
                              && !cfg1_q.pin_enable_block && !cfg_timeout_s;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (addr)
            `ADDR_STATUS0: begin
                rd_byte = s0_flags;
                rd_byte[`S0_CFG_TIMEOUT] = cfg_timeout_s;
            end
            `ADDR_STATUS1: begin
                rd_byte = s1_flags;
                rd_byte[`S1_CH1_PIN] = ev_s.ch1_enable_pin;
                rd_byte[`S1_CH2_PIN] = ev_s.ch2_enable_pin;
            end
            `ADDR_TEMPERATURE: rd_byte = temperature;
            `ADDR_CONV1_HI: rd_byte = {6'h00, conv1_result[9:8]};
            `ADDR_CONV1_LO: rd_byte = conv1_lo_q;
            `ADDR_CONV2_HI: rd_byte = {6'h00, conv2_result[9:8]};
            `ADDR_CONV2_LO: rd_byte = conv2_lo_q;
            `ADDR_CH1_CTRL: rd_byte = {cfg1_q.conv_src, cfg1_q.offset_comp_en,
                                       cfg1_q.pin_enable_block, cfg1_q.monitor_resistor_off,
                                       cfg1_q.ext_cap_connect, cfg1_q.regulation_select};
            `ADDR_CH1_OVC_THR: rd_byte = cfg1_q.ovc_threshold;
            `ADDR_CH1_MON_RES: rd_byte = cfg1_q.monitor_resistor_code;
            `ADDR_CH1_COMP_REF: rd_byte = {1'b0, cfg1_q.compensation_current,
                                           cfg1_q.saturation_threshold,
                                           cfg1_q.regulator_reference[9:8]};
            `ADDR_CH1_REF_LO: rd_byte = cfg1_q.regulator_reference[7:0];
            `ADDR_RANGE_XT: rd_byte = {4'h0, cfg1_q.ext_transistor_enable,
                                       cfg1_q.force_sense_select, 1'b0,
                                       cfg1_q.current_range};
            `ADDR_GENERAL: rd_byte = {1'b0, cfg1_q.merge, 6'h00};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_en;
            if (rd_en) begin
                rdata_q <= rd_byte;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_ram_clear;
        @(posedge clock) disable iff (reset)
        (rd_s0 && !ram_init_done) |=> !s0_flags[`S0_RAM_INIT];
    endproperty
    a_ram_clear: assert property (p_ram_clear) else $error("ram init flag not cleared by read");

    property p_set_wins;
        @(posedge clock) disable iff (reset)
        (rd_s0 && ev_s.overtemp) |=> s0_flags[`S0_OVERTEMP];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overtemp lost under clearing read");

    property p_read_old;
        @(posedge clock) disable iff (reset)
        (rd_s0 && s0_flags[`S0_OSC_WDOG]) |=> rdata_q[`S0_OSC_WDOG] && rvalid_q;
    endproperty
    a_read_old: assert property (p_read_old) else $error("watchdog flag cleared before capture");

    property p_oc1_gate;
        @(posedge clock) disable iff (reset)
        (!overcurrent1_detect_en_q && !s0_flags[`S0_OVERCURRENT1] && !rd_s0)
        |=> !s0_flags[`S0_OVERCURRENT1];
    endproperty
    a_oc1_gate: assert property (p_oc1_gate) else $error("overcurrent set while disabled");

    property p_laser_off;
        @(posedge clock) disable iff (reset)
        cfg_timeout_s |=> laser_off_q && !ch1_on_q && !ch2_on_q;
    endproperty
    a_laser_off: assert property (p_laser_off) else $error("outputs on after config timeout");

    property p_pin_block;
        @(posedge clock) disable iff (reset)
        cfg1_q.pin_enable_block |=> !ch1_on_q;
    endproperty
    a_pin_block: assert property (p_pin_block) else $error("blocked pin enabled channel 1");

    property p_pin_live;
        @(posedge clock) disable iff (reset)
        rd_s1 |=> rdata_q[`S1_CH2_PIN] == $past(ev_s.ch2_enable_pin);
    endproperty
    a_pin_live: assert property (p_pin_live) else $error("channel 2 pin level misread");

    property p_merge_down;
        @(posedge clock) disable iff (reset)
        (cfg1_q.merge && ev_s.ch1_supply_down) |=> s1_flags[`S1_CH2_SUPPLY];
    endproperty
    a_merge_down: assert property (p_merge_down) else $error("combined supply down not flagged");

    property p_snapshot;
        @(posedge clock) disable iff (reset)
        (is_read(rd_en, addr, `ADDR_CONV1_HI) ##1 !is_read(rd_en, addr, `ADDR_CONV1_HI)
         ##1 is_read(rd_en, addr, `ADDR_CONV1_LO))
        |=> rdata_q == $past(conv1_result[7:0], 3);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("converter low byte torn");

    property p_route_off;
        @(posedge clock) disable iff (reset)
        !cfg1_q.conv_src[2] |=> conv1_route_q == laser_regs_pkg::ROUTE_OFF;
    endproperty
    a_route_off: assert property (p_route_off) else $error("converter on with source code 0xx");

endmodule // laser_driver_status_config_regs

`default_nettype wire

// *** core/pin_sync3.sv ***
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change is accepted only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (reset) begin
                    sync_q[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    sync_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

endmodule // pin_sync3

`default_nettype wire

// *** core/sticky_flag_bank.sv ***
`timescale 1ns/100ps
`default_nettype none

module sticky_flag_bank #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Events and clears
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] flags_q
);

    // Set is applied after clear so a coincident event is never lost
    always_ff @(posedge clock) begin
        if (reset) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clear_in) | set_in;
        end
    end

endmodule // sticky_flag_bank

`default_nettype wire

// *** shared/laser_regs_cfg.svh ***
`ifndef LASER_REGS_CFG_SVH
`define LASER_REGS_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_STATUS0 8'h00
`define ADDR_STATUS1 8'h01
`define ADDR_TEMPERATURE 8'h02
`define ADDR_CONV1_HI 8'h03
`define ADDR_CONV1_LO 8'h04
`define ADDR_CONV2_HI 8'h05
`define ADDR_CONV2_LO 8'h06
`define ADDR_CH1_CTRL 8'h10
`define ADDR_CH1_OVC_THR 8'h11
`define ADDR_CH1_MON_RES 8'h12
`define ADDR_CH1_COMP_REF 8'h13
`define ADDR_CH1_REF_LO 8'h14
`define ADDR_RANGE_XT 8'h1a
`define ADDR_GENERAL 8'h1b

// ----------------------------------------
// Field positions
// ----------------------------------------
`define S0_RAM_INIT 0
`define S0_OVERTEMP 3
`define S0_OVERCURRENT2 4
`define S0_OVERCURRENT1 5
`define S0_OSC_WDOG 6
`define S0_CFG_TIMEOUT 7
`define S1_CH1_PIN 0
`define S1_CH1_SEEN 1
`define S1_CH1_SAT 2
`define S1_CH1_SUPPLY 3
`define S1_CH2_PIN 4
`define S1_CH2_SEEN 5
`define S1_CH2_SAT 6
`define S1_CH2_SUPPLY 7
`define RX_RANGE 0
`define RX_FORCE 2
`define RX_EXT_TR 3
`define GEN_MERGE 6

// ----------------------------------------
// Reset values and the overcurrent detect-off threshold
// ----------------------------------------
`define RST_CH1_CTRL 8'h18
`define RST_OVC_THR 8'hff
`define RST_MON_RES 8'hff
`define RST_COMP 3'h3
`define RST_SAT_THR 2'h0
`define RST_REF 10'h000
`define OVC_THR_OFF 8'h00

`endif

// *** shared/laser_regs_pkg.sv ***
package laser_regs_pkg;

    // Asynchronous analog and pin events
    typedef struct packed {
        logic overtemp;
        logic overcurrent1;
        logic overcurrent2;
        logic osc_fail;
        logic cfg_mode;
        logic cfg_timeout;
        logic ch1_enable_pin;
        logic ch2_enable_pin;
        logic ch1_sat;
        logic ch2_sat;
        logic ch1_supply_down;
        logic ch2_supply_down;
        logic supplies_differ;
    } event_t;

    // Channel 1 and general configuration fields
    typedef struct packed {
        logic [2:0] conv_src;
        logic offset_comp_en;
        logic pin_enable_block;
        logic monitor_resistor_off;
        logic ext_cap_connect;
        logic regulation_select;
        logic [7:0] ovc_threshold;
        logic [7:0] monitor_resistor_code;
        logic [2:0] compensation_current;
        logic [1:0] saturation_threshold;
        logic [9:0] regulator_reference;
        logic ext_transistor_enable;
        logic force_sense_select;
        logic current_range;
        logic merge;
    } cfg1_t;

    // Converter input routing for channel 1
    typedef enum logic [2:0] {
        ROUTE_OFF,
        ROUTE_MON_SENSE,
        ROUTE_PHOTODIODE_FORCE,
        ROUTE_MAIN_SUPPLY,
        ROUTE_CH_SUPPLY,
        ROUTE_DRIVER_OUT
    } conv_route_t;

endpackage

// *** tb/laser_driver_status_config_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module laser_driver_status_config_regs_tb;
    logic clock;
    logic reset;
    logic ram_init_done;
    logic [7:0] temperature;
    logic [9:0] conv1_result;
    logic [9:0] conv2_result;
    laser_regs_pkg::event_t events;
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata_q;
    logic rvalid_q;
    laser_regs_pkg::cfg1_t cfg1_q;
    laser_regs_pkg::conv_route_t conv1_route_q;
    logic overcurrent1_detect_en_q;
    logic laser_off_q;
    logic ch1_on_q;
    logic ch2_on_q;
    logic ch2_parallel_q;
    logic [7:0] exp_q[$];
    logic [7:0] d;
    logic [31:0] lfsr = 32'h2c20;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] ra [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h1a, 8'h0f};
    logic [7:0] rv [7] = '{8'h18, 8'hff, 8'hff, 8'h30, 8'h00, 8'h00, 8'h00};
    logic [2:0] re [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5};

    laser_host_model u_host (.clock(clock), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
        .wdata(wdata));
    laser_driver_status_config_regs u_dut (.clock(clock), .reset(reset), .rd_en(rd_en),
        .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
        .ram_init_done(ram_init_done), .temperature(temperature),
        .conv1_result(conv1_result), .conv2_result(conv2_result), .events(events),
        .cfg1_q(cfg1_q), .conv1_route_q(conv1_route_q),
        .overcurrent1_detect_en_q(overcurrent1_detect_en_q),
        .laser_off_q(laser_off_q), .ch1_on_q(ch1_on_q), .ch2_on_q(ch2_on_q),
        .ch2_parallel_q(ch2_parallel_q));

    // --------
    // Helpers
    // --------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Events are asynchronous: hold past the synchroniser before releasing
    task automatic pulse(input laser_regs_pkg::event_t e);
        events = e;
        settle(6);
        events = '0;
        settle(6);
    endtask
    task automatic final_report();
        $display("TB: checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // An unexpected answer is compared against its own inverse so it counts
    always @(posedge clock) begin
        cycles++;
        if (rvalid_q === 1'b1) chk(exp_q.size() > 0 ? exp_q.pop_front() : ~rdata_q, rdata_q);
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // --------
    // Scenarios
    // --------
    initial begin
        reset = 1'b1;
        ram_init_done = 1'b0;
        temperature = 8'h00;
        conv1_result = 10'h000;
        conv2_result = 10'h000;
        events = '0;
        repeat (5) @(posedge clock);
        #1;
        reset = 1'b0;
        settle(2);
        for (int i = 0; i < 7; i++) rd_exp(ra[i], rv[i]);
        chk(8'h01, {6'h00, laser_off_q, overcurrent1_detect_en_q});
        $display("TB: reset values done");
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            u_host.wr(8'h11, lfsr[7:0]);
            rd_exp(8'h11, lfsr[7:0]);
            u_host.wr(8'h12, lfsr[15:8]);
            rd_exp(8'h12, lfsr[15:8]);
            chk(lfsr[15:8], cfg1_q.monitor_resistor_code);
            u_host.wr(8'h13, lfsr[23:16]);
            rd_exp(8'h13, lfsr[23:16] & 8'h7f);
            u_host.wr(8'h1a, lfsr[31:24]);
            rd_exp(8'h1a, lfsr[31:24] & 8'h0d);
            temperature = lfsr[7:0];
            u_host.wr(8'h02, ~lfsr[7:0]);
            rd_exp(8'h02, lfsr[7:0]);
        end
        u_host.wr(8'h1a, 8'h00);
        for (int c = 0; c < 8; c++) begin
            u_host.wr(8'h10, {c[2:0], 5'h08});
            settle(2);
            chk({5'h00, re[c]}, {5'h00, conv1_route_q});
        end
        u_host.wr(8'h10, 8'h89);
        u_host.wr(8'h1a, 8'h04);
        u_host.wr(8'h11, 8'h00);
        settle(2);
        chk(8'h04, {4'h0, conv1_route_q, overcurrent1_detect_en_q});
        pulse('{overcurrent1: 1'b1, default: 1'b0});
        rd_exp(8'h00, 8'h00);
        u_host.wr(8'h11, 8'h01);
        $display("TB: config done");
        ram_init_done = 1'b1;
        settle(1);
        ram_init_done = 1'b0;
        pulse('{overtemp: 1'b1, overcurrent1: 1'b1, overcurrent2: 1'b1, osc_fail: 1'b1,
                default: 1'b0});
        rd_exp(8'h00, 8'h79);
        rd_exp(8'h00, 8'h00);
        events.overtemp = 1'b1;
        settle(6);
        rd_exp(8'h00, 8'h08);
        rd_exp(8'h00, 8'h08);
        events = '0;
        settle(6);
        rd_exp(8'h00, 8'h08);
        rd_exp(8'h00, 8'h00);
        events.cfg_mode = 1'b1;
        events.cfg_timeout = 1'b1;
        settle(8);
        chk(8'h01, {7'h00, laser_off_q});
        rd_exp(8'h00, 8'h80);
        events = '0;
        settle(8);
        chk(8'h00, {7'h00, laser_off_q});
        $display("TB: status0 done");
        pulse('{ch1_enable_pin: 1'b1, ch2_sat: 1'b1, ch1_supply_down: 1'b1, default: 1'b0});
        rd_exp(8'h01, 8'h4a);
        events = '{ch2_enable_pin: 1'b1, ch1_sat: 1'b1, ch2_supply_down: 1'b1, default: 1'b0};
        settle(6);
        chk(8'h01, {7'h00, ch2_on_q});
        rd_exp(8'h01, 8'hb4);
        events = '0;
        settle(6);
        rd_exp(8'h01, 8'ha4);
        rd_exp(8'h01, 8'h00);
        u_host.wr(8'h1b, 8'hff);
        rd_exp(8'h1b, 8'h40);
        pulse('{ch1_supply_down: 1'b1, default: 1'b0});
        rd_exp(8'h01, 8'h88);
        pulse('{supplies_differ: 1'b1, default: 1'b0});
        rd_exp(8'h01, 8'h08);
        u_host.wr(8'h10, 8'h00);
        events.ch1_enable_pin = 1'b1;
        settle(8);
        chk(8'h05, {5'h00, ch1_on_q, ch2_on_q, ch2_parallel_q});
        rd_exp(8'h01, 8'h03);
        events = '0;
        $display("TB: status1 done");
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            conv1_result = (i == 0) ? 10'h3ff : lfsr[9:0];
            conv2_result = lfsr[19:10];
            settle(1);
            rd_exp(8'h03, {6'h00, conv1_result[9:8]});
            d = conv1_result[7:0];
            conv1_result = ~conv1_result;
            rd_exp(8'h04, d);
            rd_exp(8'h05, {6'h00, conv2_result[9:8]});
            d = conv2_result[7:0];
            conv2_result = ~conv2_result;
            rd_exp(8'h06, d);
        end
        settle(4);
        chk(8'h00, 8'(exp_q.size()));
        $display("TB: converter done");
        final_report();
    end
endmodule // laser_driver_status_config_regs_tb

`default_nettype wire

// *** tb/laser_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module laser_host_model (
    // Clock
    input wire logic clock,
    // Register access
    output logic rd_en,
    output logic wr_en,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // One request per call, held for exactly the edge that takes it
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clock);
        #1;
        rd_en = 1'b0;
        addr = ~a;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clock);
        #1;
        wr_en = 1'b0;
        wdata = ~d;
    endtask
endmodule // laser_host_model

`default_nettype wire
